// ==== debounce_if.sv ====
// Carrier between the link controller and its pin debouncer
interface debounce_if;
	import redriver_pkg::*;
	logic [NPIN-1:0] raw;
	logic [NPIN-1:0] clean;
	modport ctl (output raw, input clean);
	modport deb (input raw, output clean);
endinterface

// ==== pin_debounce.sv ====
// Debouncer for the slow control pins
module pin_debounce
	import redriver_pkg::*;
#(
	parameter int DB_CYCLES = CTL_DB_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	debounce_if.deb pins
);

	localparam logic [DB_W-1:0] DB_LAST = DB_W'(DB_CYCLES - 1);

	logic [DB_W-1:0] cnt_r [NPIN];
	logic [NPIN-1:0] clean_r;

	// A pin must hold a new level for the full window; a glitch restarts it
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < NPIN; i++)
				cnt_r[i] <= '0;
			clean_r <= '0;
		end
		else if (ce)
		begin
			for (int i = 0; i < NPIN; i++)
			begin
				if (pins.raw[i] == clean_r[i])
					cnt_r[i] <= '0;
				else if (cnt_r[i] == DB_LAST)
				begin
					cnt_r[i] <= '0;
					clean_r[i] <= pins.raw[i];
				end
				else
					cnt_r[i] <= cnt_r[i] + 1'b1;
			end
		end
	end

	assign pins.clean = clean_r;

endmodule

// ==== redriver_link_power_fsm.sv ====
// Link power state machine and equalization control for the redriver
// --------------------------------------------------------------------
// --------------------------------------------------------------------
//
// The register offsets and the address-and-strobe port were left to the implementer.
module redriver_link_power_fsm
	import redriver_pkg::*;
#(
	parameter int PG_CYCLES = PG_CYC,
	parameter int DB_CYCLES = CTL_DB_CYC,
	parameter int DET_CYCLES = DET_CYC,
	parameter int U1_IDLE_CYCLES = U1_IDLE_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic supply_ok,
	input wire redriver_pkg::lvl_t mode_sel_pin,
	input wire redriver_pkg::lvl_t dfp_gain_pin_high,
	input wire redriver_pkg::lvl_t dfp_gain_pin_low,
	input wire redriver_pkg::lvl_t ufp_gain_pin_high,
	input wire redriver_pkg::lvl_t ufp_gain_pin_low,
	input wire logic test_strap_pin,
	input wire logic usb_enable_pin,
	input wire logic orient_pin,
	input wire logic ufp_term_det,
	input wire logic dfp_term_det,
	input wire logic ufp_elec_idle,
	input wire logic dfp_elec_idle,
	input wire logic ufp_lfps,
	input wire logic dfp_lfps,
	input wire redriver_pkg::reg_addr_t reg_addr,
	input wire redriver_pkg::reg_data_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic power_good,
	output logic bias_off,
	output logic reg_mode,
	output redriver_pkg::link_state_t link_state,
	output logic redrive_en,
	output logic rx_term_en,
	output logic tx_cm_en,
	output logic rx_detect_req,
	output logic eq_on,
	output redriver_pkg::eq_idx_t eq_lane_a,
	output redriver_pkg::eq_idx_t eq_lane_b,
	output redriver_pkg::eq_idx_t eq_upstream,
	output logic orient,
	output logic test_mode
);
	import redriver_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Levels 0,R,F,1 weigh 0..3; high pin weighs four
	function automatic eq_idx_t eq_index(input lvl_t hi, input lvl_t lo);
		eq_index = {hi, lo};
	endfunction

	function automatic eq_idx_t field(input reg_data_t r, input int lsb);
		field = r[lsb +: 4];
	endfunction

	localparam logic [PG_W-1:0] PG_LAST = PG_W'(PG_CYCLES - 1);
	localparam logic [HD_W-1:0] HD_LAST = HD_W'(CFG_HD_CYC - 1);
	localparam logic [DET_W-1:0] DET_LAST = DET_W'(DET_CYCLES - 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(U1_IDLE_CYCLES - 1);

	// ----------------------------------------------------------------
	// Power good
	// ----------------------------------------------------------------
	logic [PG_W-1:0] pg_cnt_r;
	logic pg_r;

	// Counts from supply at minimum; a supply drop restarts the wait
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pg_cnt_r <= '0;
			pg_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!supply_ok)
			begin
				pg_cnt_r <= '0;
				pg_r <= 1'b0;
			end
			else if (!pg_r)
			begin
				if (pg_cnt_r == PG_LAST)
					pg_r <= 1'b1;
				else
					pg_cnt_r <= pg_cnt_r + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration latch
	// ----------------------------------------------------------------
	logic pg_d_r;
	logic [HD_W-1:0] hd_cnt_r;
	logic bias_off_r;
	logic reg_mode_r;
	lvl_t dfp_hi_r;
	lvl_t dfp_lo_r;
	lvl_t ufp_hi_r;
	lvl_t ufp_lo_r;
	logic pg_rise;

	assign pg_rise = pg_r && !pg_d_r;

	// Sampled once at internal reset release; the board keeps the pins
	// steady across this edge, so no filtering is done here
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pg_d_r <= 1'b0;
			reg_mode_r <= 1'b0;
			dfp_hi_r <= LVL_0;
			dfp_lo_r <= LVL_0;
			ufp_hi_r <= LVL_0;
			ufp_lo_r <= LVL_0;
		end
		else if (ce)
		begin
			pg_d_r <= pg_r;
			if (pg_rise)
			begin
				reg_mode_r <= (mode_sel_pin != LVL_0);
				dfp_hi_r <= dfp_gain_pin_high;
				dfp_lo_r <= dfp_gain_pin_low;
				ufp_hi_r <= ufp_gain_pin_high;
				ufp_lo_r <= ufp_gain_pin_low;
			end
		end
	end

	// Bias resistors isolated after the hold time to save power
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hd_cnt_r <= '0;
			bias_off_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!pg_r)
			begin
				hd_cnt_r <= '0;
				bias_off_r <= 1'b0;
			end
			else if (!bias_off_r)
			begin
				if (hd_cnt_r == HD_LAST)
					bias_off_r <= 1'b1;
				else
					hd_cnt_r <= hd_cnt_r + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control pin debounce
	// ----------------------------------------------------------------
	debounce_if dbi ();

	assign dbi.raw = {orient_pin, usb_enable_pin, test_strap_pin};

	pin_debounce #(
		.DB_CYCLES(DB_CYCLES)
	) u_deb (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.pins(dbi.deb)
	);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	reg_data_t ctrl_r;
	reg_data_t eq_dfp_r;
	reg_data_t eq_ufp_r;
	reg_data_t rdata_r;
	link_state_t state_r;
	logic any_lfps;

	assign any_lfps = ufp_lfps || dfp_lfps;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_r <= CTRL_RST;
			eq_dfp_r <= EQ_DFP_RST;
			eq_ufp_r <= EQ_UFP_RST;
		end
		else if (ce && reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CTRL: ctrl_r <= reg_wdata;
				ADDR_EQ_DFP: eq_dfp_r <= reg_wdata;
				ADDR_EQ_UFP: eq_ufp_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata_r <= '0;
		else if (ce)
		begin
			rdata_r <= '0;
			if (reg_rd)
			begin
				unique case (reg_addr)
					ADDR_CTRL: rdata_r <= ctrl_r;
					ADDR_EQ_DFP: rdata_r <= eq_dfp_r;
					ADDR_EQ_UFP: rdata_r <= eq_ufp_r;
					ADDR_STATUS: rdata_r <= {dbi.clean[PIN_TEST], dbi.clean[PIN_ORIENT],
						any_lfps, bias_off_r, pg_r, reg_mode_r, state_r};
					default: rdata_r <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Link power state machine
	// ----------------------------------------------------------------
	logic usb_on;
	logic both_term;
	logic both_idle;
	logic [DET_W-1:0] det_cnt_r;
	logic det_req_r;
	logic det_chk_r;
	logic [IDLE_W-1:0] idle_cnt_r;
	link_state_t state_nxt;

	assign usb_on = pg_r && (dbi.clean[PIN_EN] || ctrl_r[CTRL_EN_BIT]);
	assign both_term = ufp_term_det && dfp_term_det;
	assign both_idle = ufp_elec_idle && dfp_elec_idle;

	// Periodic far-end detect while the link is down or in U2/U3
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			det_cnt_r <= '0;
			det_req_r <= 1'b0;
			det_chk_r <= 1'b0;
		end
		else if (ce)
		begin
			det_chk_r <= det_req_r;
			det_req_r <= 1'b0;
			if (!usb_on || state_r == ST_U0 || state_r == ST_U1)
				det_cnt_r <= '0;
			else if (det_cnt_r == DET_LAST)
			begin
				det_cnt_r <= '0;
				det_req_r <= 1'b1;
			end
			else
				det_cnt_r <= det_cnt_r + 1'b1;
		end
	end

	// Idle time spent in U1 before dropping to U2/U3
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			idle_cnt_r <= '0;
		else if (ce)
		begin
			if (state_r != ST_U1 || !both_idle || any_lfps)
				idle_cnt_r <= '0;
			else if (idle_cnt_r != IDLE_LAST)
				idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_DISC:
				if (both_term)
					state_nxt = ST_U0;
			ST_U0:
				if (both_idle)
					state_nxt = ST_U1;
			ST_U1:
				if (any_lfps || !both_idle)
					state_nxt = ST_U0;
				else if (idle_cnt_r == IDLE_LAST)
					state_nxt = ST_U23;
			ST_U23:
				if (det_chk_r && !both_term)
					state_nxt = ST_DISC;
				else if (any_lfps)
					state_nxt = ST_U0;
		endcase
		if (!usb_on)
			state_nxt = ST_DISC;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_r <= ST_DISC;
		else if (ce)
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// Port controls, registered from the next state
	// ----------------------------------------------------------------
	logic redrive_r;
	logic term_r;
	logic cm_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			redrive_r <= 1'b0;
			term_r <= 1'b0;
			cm_r <= 1'b0;
		end
		else if (ce)
		begin
			redrive_r <= (state_nxt == ST_U0);
			term_r <= (state_nxt != ST_DISC);
			cm_r <= (state_nxt == ST_U0) || (state_nxt == ST_U1);
		end
	end

	// ----------------------------------------------------------------
	// Equalization select
	// ----------------------------------------------------------------
	eq_idx_t eq_a_r;
	eq_idx_t eq_b_r;
	eq_idx_t eq_u_r;
	logic eq_on_r;

	// In pin mode both downstream lanes share the one pin pair
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			eq_a_r <= '0;
			eq_b_r <= '0;
			eq_u_r <= '0;
			eq_on_r <= 1'b0;
		end
		else if (ce)
		begin
			eq_on_r <= !any_lfps;
			if (reg_mode_r)
			begin
				eq_a_r <= field(eq_dfp_r, LANE_A_LSB);
				eq_b_r <= field(eq_dfp_r, LANE_B_LSB);
				eq_u_r <= field(eq_ufp_r, UPS_LSB);
			end
			else
			begin
				eq_a_r <= eq_index(dfp_hi_r, dfp_lo_r);
				eq_b_r <= eq_index(dfp_hi_r, dfp_lo_r);
				eq_u_r <= eq_index(ufp_hi_r, ufp_lo_r);
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign power_good = pg_r;
	assign bias_off = bias_off_r;
	assign reg_mode = reg_mode_r;
	assign link_state = state_r;
	assign redrive_en = redrive_r;
	assign rx_term_en = term_r;
	assign tx_cm_en = cm_r;
	assign rx_detect_req = det_req_r;
	assign eq_on = eq_on_r;
	assign eq_lane_a = eq_a_r;
	assign eq_lane_b = eq_b_r;
	assign eq_upstream = eq_u_r;
	assign orient = dbi.clean[PIN_ORIENT];
	assign test_mode = dbi.clean[PIN_TEST];

endmodule

// ==== redriver_link_power_fsm_assertions.sv ====
// Concurrent checks on the ports of the redriver link control block
module redriver_link_power_fsm_chk
	import redriver_pkg::*;
#(
	parameter int DET_CYCLES = 16
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire redriver_pkg::lvl_t mode_sel_pin,
	input wire redriver_pkg::lvl_t dfp_gain_pin_high,
	input wire redriver_pkg::lvl_t dfp_gain_pin_low,
	input wire redriver_pkg::lvl_t ufp_gain_pin_high,
	input wire redriver_pkg::lvl_t ufp_gain_pin_low,
	input wire logic ufp_term_det,
	input wire logic dfp_term_det,
	input wire logic ufp_elec_idle,
	input wire logic dfp_elec_idle,
	input wire logic ufp_lfps,
	input wire logic dfp_lfps,
	input wire logic power_good,
	input wire logic bias_off,
	input wire logic reg_mode,
	input wire redriver_pkg::link_state_t link_state,
	input wire logic redrive_en,
	input wire logic rx_term_en,
	input wire logic tx_cm_en,
	input wire logic rx_detect_req,
	input wire logic eq_on,
	input wire redriver_pkg::eq_idx_t eq_lane_a,
	input wire redriver_pkg::eq_idx_t eq_lane_b,
	input wire redriver_pkg::eq_idx_t eq_upstream
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [15:0] gap_r;
	logic [10:0] pg_cnt_r;
	wire any_lfps = ufp_lfps | dfp_lfps;
	wire both_term = ufp_term_det & dfp_term_det;
	wire both_idle = ufp_elec_idle & dfp_elec_idle;
	// ----
	// Helper counters
	// ----
	// Gap restarts on U2/U3 entry, so a free-running detect timer still fits
	always_ff @(posedge clk_sys)
	begin
		if (rst || rx_detect_req || link_state != ST_U23)
			gap_r <= '0;
		else if (ce)
			gap_r <= gap_r + 16'h0001;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst || !power_good)
			pg_cnt_r <= '0;
		else if (ce && pg_cnt_r != 11'h7ff)
			pg_cnt_r <= pg_cnt_r + 11'h001;
	end
	// ----
	// Properties
	// ----
	disc_hold_a: assert property (ce && link_state == ST_DISC && !both_term
		|=> link_state == ST_DISC)
		else $error("left disconnect without both terminations");
	disc_exit_a: assert property ((link_state == ST_DISC ##1 link_state != ST_DISC)
		|-> link_state == ST_U0)
		else $error("disconnect exit not to U0");
	u0_hold_a: assert property (ce && link_state == ST_U0 && !both_idle
		|=> link_state inside {ST_U0, ST_DISC})
		else $error("left U0 while traffic present");
	u0_idle_a: assert property (ce && link_state == ST_U0 && both_idle
		|=> link_state inside {ST_U1, ST_DISC})
		else $error("idle in U0 did not reach U1");
	u0_drive_a: assert property (link_state == ST_U0 |-> redrive_en && rx_term_en && tx_cm_en)
		else $error("U0 outputs wrong");
	u1_power_a: assert property (link_state == ST_U1 |-> rx_term_en && tx_cm_en && !redrive_en)
		else $error("U1 outputs wrong");
	u23_power_a: assert property (link_state == ST_U23
		|-> rx_term_en && !tx_cm_en && !redrive_en)
		else $error("U2/U3 outputs wrong");
	lfps_wake_a: assert property (ce && link_state == ST_U23 && any_lfps
		|=> link_state inside {ST_U0, ST_DISC})
		else $error("LFPS in U2/U3 did not wake");
	u1_wake_a: assert property (ce && link_state == ST_U1 && any_lfps
		|=> link_state inside {ST_U0, ST_DISC})
		else $error("LFPS in U1 did not wake");
	pg_gate_a: assert property (ce && !power_good |=> link_state == ST_DISC)
		else $error("link active without power good");
	det_period_a: assert property (gap_r <= DET_CYCLES + 1)
		else $error("detect pulse overdue");
	det_pulse_a: assert property (rx_detect_req |=> !rx_detect_req)
		else $error("detect pulse too long");
	eq_gate_a: assert property (ce && !rst |=> eq_on == !$past(any_lfps))
		else $error("equalizer gate wrong");
	mode_latch_a: assert property ($rose(power_good)
		|=> reg_mode == ($past(mode_sel_pin) != LVL_0))
		else $error("config mode latched wrong");
	bias_time_a: assert property ($rose(bias_off) |-> pg_cnt_r inside {[998:1002]})
		else $error("bias isolation at wrong time");
	pin_index_a: assert property ($rose(bias_off) && !reg_mode |->
		eq_lane_a == eq_idx_t'(4 * dfp_gain_pin_high + dfp_gain_pin_low)
		&& eq_lane_b == eq_lane_a
		&& eq_upstream == eq_idx_t'(4 * ufp_gain_pin_high + ufp_gain_pin_low))
		else $error("pin gain index wrong");
	cover property (link_state == ST_U23 ##1 link_state == ST_U0);
	cover property (link_state == ST_U23 ##1 link_state == ST_DISC);
	cover property ($rose(bias_off));
endmodule

// ==== redriver_link_power_fsm_tb.sv ====
// Self-checking bench for the redriver link control block
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module redriver_link_power_fsm_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import redriver_pkg::*;
	localparam int PG = 20;
	localparam int DB = 8;
	localparam int DET = 16;
	localparam int U1I = 10;
	logic clk_sys, rst, ce, supply_ok, test_strap_pin, usb_enable_pin, orient_pin, reg_wr, reg_rd;
	lvl_t mode_sel_pin, dfp_gain_pin_high, dfp_gain_pin_low, ufp_gain_pin_high, ufp_gain_pin_low;
	logic ufp_term_det, dfp_term_det, ufp_elec_idle, dfp_elec_idle, ufp_lfps, dfp_lfps;
	reg_addr_t reg_addr;
	reg_data_t reg_wdata;
	logic [7:0] reg_rdata;
	logic power_good, bias_off, reg_mode, redrive_en, rx_term_en, tx_cm_en, rx_detect_req;
	logic eq_on, orient, test_mode, attach, active, burst, drop_dfp;
	link_state_t link_state;
	eq_idx_t eq_lane_a, eq_lane_b, eq_upstream;
	int bad_count = 0;
	int total_checks = 0;

	redriver_link_power_fsm #(.PG_CYCLES(PG), .DB_CYCLES(DB), .DET_CYCLES(DET),
		.U1_IDLE_CYCLES(U1I)) dut_u (.*);
	usb_phy_model phy_u (.*);

	initial
	begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ----
	// Bus and wait helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wst(input link_state_t s, input int n);
		for (int i = 0; i < n && link_state !== s; i++)
			cyc(1);
	endtask
	task automatic wr(input reg_addr_t a, input reg_data_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input reg_addr_t a, output reg_data_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic px(input logic a, input logic b, input logic dd, input link_state_t s,
		input int n);
		@(posedge clk_sys);
		active <= a;
		burst <= b;
		drop_dfp <= dd;
		wst(s, n);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_power;
		int n;
		@(posedge clk_sys);
		supply_ok <= 1'h1;
		for (n = 0; n < PG + 5 && power_good !== 1'h1; n++)
			cyc(1);
		`CHK(n <= PG + 2, 1'h1)
		cyc(985);
		`CHK(bias_off, 1'h0)
		for (n = 0; n < 30 && bias_off !== 1'h1; n++)
			cyc(1);
		`CHK(bias_off, 1'h1)
		`CHK(reg_mode, 1'h0)
		`CHK(eq_lane_a, 4'h9)
		`CHK(eq_lane_b, 4'h9)
		`CHK(eq_upstream, 4'he)
		$display("power-up test done");
	endtask
	task automatic t_regs;
		reg_data_t v;
		rd(ADDR_CTRL, v);
		`CHK(v, CTRL_RST)
		wr(ADDR_EQ_DFP, 8'h5a);
		rd(ADDR_EQ_DFP, v);
		`CHK(v, 8'h5a)
		rd(8'h40, v);
		`CHK(v, 8'h00)
		`CHK(eq_lane_a, 4'h9)
		@(posedge clk_sys);
		supply_ok <= 1'h0;
		mode_sel_pin <= LVL_F;
		cyc(3);
		@(posedge clk_sys);
		supply_ok <= 1'h1;
		cyc(PG + 1010);
		`CHK(reg_mode, 1'h1)
		wr(ADDR_EQ_DFP, 8'h5a);
		wr(ADDR_EQ_UFP, 8'h0c);
		cyc(2);
		`CHK(eq_lane_a, 4'ha)
		`CHK(eq_lane_b, 4'h5)
		`CHK(eq_upstream, 4'hc)
		$display("register test done");
	endtask
	task automatic t_link;
		reg_data_t v;
		@(posedge clk_sys);
		attach <= 1'h1;
		px(1, 0, 0, ST_U0, 5);
		`CHK(link_state, ST_U0)
		`CHK(redrive_en, 1'h1)
		rd(ADDR_STATUS, v);
		`CHK(v, 8'h1f)
		px(0, 0, 0, ST_U1, 5);
		`CHK(link_state, ST_U1)
		`CHK(tx_cm_en, 1'h1)
		px(1, 0, 0, ST_U0, 5);
		`CHK(link_state, ST_U0)
		px(0, 0, 0, ST_U1, 5);
		px(0, 1, 0, ST_U0, 5);
		`CHK(link_state, ST_U0)
		px(0, 0, 0, ST_U1, 5);
		wst(ST_U23, U1I + 6);
		`CHK(link_state, ST_U23)
		`CHK(tx_cm_en, 1'h0)
		`CHK(rx_term_en, 1'h1)
		px(0, 1, 0, ST_U0, 5);
		`CHK(link_state, ST_U0)
		`CHK(eq_on, 1'h0)
		px(0, 0, 0, ST_U1, 5);
		wst(ST_U23, U1I + 6);
		`CHK(eq_on, 1'h1)
		px(0, 0, 1, ST_DISC, DET + 8);
		`CHK(link_state, ST_DISC)
		`CHK(rx_term_en, 1'h0)
		$display("link test done");
	endtask
	task automatic t_pins;
		reg_data_t v;
		px(1, 0, 0, ST_U0, 5);
		wr(ADDR_CTRL, 8'h00);
		cyc(3);
		`CHK(link_state, ST_DISC)
		@(posedge clk_sys);
		usb_enable_pin <= 1'h1;
		orient_pin <= 1'h1;
		test_strap_pin <= 1'h1;
		wst(ST_U0, DB + 6);
		`CHK(link_state, ST_U0)
		`CHK(test_mode, 1'h1)
		@(posedge clk_sys);
		usb_enable_pin <= 1'h0;
		orient_pin <= 1'h0;
		cyc(3);
		@(posedge clk_sys);
		orient_pin <= 1'h1;
		wst(ST_DISC, DB + 6);
		`CHK(link_state, ST_DISC)
		`CHK(orient, 1'h1)
		// Enable low: a write must not land and the link must not wake
		@(posedge clk_sys);
		ce <= 1'h0;
		wr(ADDR_CTRL, 8'h01);
		cyc(2);
		`CHK(link_state, ST_DISC)
		@(posedge clk_sys);
		ce <= 1'h1;
		rd(ADDR_CTRL, v);
		`CHK(v, 8'h00)
		$display("pin debounce test done");
	endtask
	// ----
	// Run control
	// ----
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		rst = 1'h1;
		ce = 1'h1;
		{supply_ok, test_strap_pin, usb_enable_pin, orient_pin, reg_wr, reg_rd} = '0;
		{attach, active, burst, drop_dfp} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		mode_sel_pin = LVL_0;
		dfp_gain_pin_high = LVL_F;
		dfp_gain_pin_low = LVL_R;
		ufp_gain_pin_high = LVL_1;
		ufp_gain_pin_low = LVL_F;
		repeat (6) @(posedge clk_sys);
		rst <= 1'h0;
		cyc(2);
		t_power();
		t_regs();
		t_link();
		t_pins();
		give_verdict();
	end
	// Whole run is near 2200 cycles; this leaves wide margin
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		give_verdict();
	end
endmodule

bind redriver_link_power_fsm redriver_link_power_fsm_chk #(.DET_CYCLES(DET_CYCLES)) chk_u (.*);

// ==== redriver_pkg.sv ====
// Shared constants and types for the redriver link control block
package redriver_pkg;

	// ----------------------------------------------------------------
	// Four-level pin codes
	// ----------------------------------------------------------------
	typedef logic [1:0] lvl_t;
	localparam lvl_t LVL_0 = 2'h0;
	localparam lvl_t LVL_R = 2'h1;
	localparam lvl_t LVL_F = 2'h2;
	localparam lvl_t LVL_1 = 2'h3;

	typedef logic [3:0] eq_idx_t;

	// ----------------------------------------------------------------
	// Link power states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_DISC = 2'b00,
		ST_U23 = 2'b01,
		ST_U1 = 2'b10,
		ST_U0 = 2'b11
	} link_state_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_PG_US = 500;
	localparam int T_CFG_HD_US = 10;
	localparam int T_CTL_DB_MS = 16;
	localparam int T_DET_US = 100;
	localparam int T_U1_IDLE_US = 50;
	// Longest time: round down
	localparam int PG_CYC = T_PG_US * CLK_MHZ;
	// Least time: round up (exact at this rate)
	localparam int CFG_HD_CYC = T_CFG_HD_US * CLK_MHZ;
	localparam int CTL_DB_CYC = T_CTL_DB_MS * 1000 * CLK_MHZ;
	localparam int DET_CYC = T_DET_US * CLK_MHZ;
	localparam int U1_IDLE_CYC = T_U1_IDLE_US * CLK_MHZ;

	localparam int PG_W = 16;
	localparam int HD_W = 10;
	localparam int DB_W = 21;
	localparam int DET_W = 14;
	localparam int IDLE_W = 13;

	// ----------------------------------------------------------------
	// Debounced control pins
	// ----------------------------------------------------------------
	localparam int NPIN = 3;
	localparam int PIN_TEST = 0;
	localparam int PIN_EN = 1;
	localparam int PIN_ORIENT = 2;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	typedef logic [7:0] reg_addr_t;
	typedef logic [7:0] reg_data_t;
	localparam reg_addr_t ADDR_CTRL = 8'h00;
	localparam reg_addr_t ADDR_EQ_DFP = 8'h01;
	localparam reg_addr_t ADDR_EQ_UFP = 8'h02;
	localparam reg_addr_t ADDR_STATUS = 8'h03;

	localparam reg_data_t CTRL_RST = 8'h01;
	localparam reg_data_t EQ_DFP_RST = 8'h00;
	localparam reg_data_t EQ_UFP_RST = 8'h00;
	localparam int CTRL_EN_BIT = 0;
	localparam int LANE_A_LSB = 0;
	localparam int LANE_B_LSB = 4;
	localparam int UPS_LSB = 0;

endpackage

// ==== usb_phy_model.sv ====
// Behavioural transceivers standing on both ports of the redriver
module usb_phy_model
(
	input wire logic clk_sys,
	input wire logic attach,
	input wire logic active,
	input wire logic burst,
	input wire logic drop_dfp,
	output logic ufp_term_det,
	output logic dfp_term_det,
	output logic ufp_elec_idle,
	output logic dfp_elec_idle,
	output logic ufp_lfps,
	output logic dfp_lfps
);
	timeunit 1ns;
	timeprecision 1ps;
	// Commands change only after edges, so these follow them cleanly
	assign ufp_term_det = attach;
	assign dfp_term_det = attach & ~drop_dfp;
	// A burst is line activity too, so it lifts ufp_elec_idle; dfp_elec_idle follows active only
	assign ufp_elec_idle = ~(attach & (active | burst));
	assign dfp_elec_idle = ~(attach & active);
	assign ufp_lfps = attach & burst;
	assign dfp_lfps = attach & burst;
endmodule
